// File: dv/ocd_feed_model.sv
/*
 Prefetch queue and datapath model facing the opcode decoder.
 Assumes the bench queues bytes in tx_q and reads decodes from rx_q.
*/
`timescale 1ns/100ps
`default_nettype none

module ocd_feed_model
    import ocd_pkg::*;
(
    // Clock, reset and pacing
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [1:0]       ready_mode,
    // Byte stream
    output logic                  byte_valid,
    output logic [7:0]            byte_data,
    input  wire logic             byte_ready,
    // Decoded instruction
    input  wire logic             dec_valid,
    output logic                  dec_ready,
    input  wire ocd_pkg::ocd_op_t dec_op,
    input  wire logic             dec_has_modrm,
    input  wire logic [7:0]       dec_modrm,
    input  wire logic             dec_unknown,
    input  wire logic [7:0]       dec_opcode
);
    logic [7:0]  tx_q[$];
    logic [20:0] rx_q[$];
    logic        phase;
    logic        nv;
    logic [7:0]  nd;
    logic [1:0]  mode_s;

    initial
    begin
        byte_valid = 1'b0;
        byte_data  = 8'h5a;
        dec_ready  = 1'b0;
        phase      = 1'b0;
    end

    // ========================================================
    // Everything sampled at the edge, applied just after it
    always @(posedge ref_clk)
    begin
        mode_s = ready_mode;
        if (resetn && dec_valid && dec_ready)
            rx_q.push_back({dec_op, dec_has_modrm, dec_modrm, dec_unknown, dec_opcode});
        if (resetn && byte_valid && byte_ready)
            void'(tx_q.pop_front());
        nv = resetn && (tx_q.size() != 0);
        nd = nv ? tx_q[0] : ~byte_data;
        #1;
        phase      = ~phase;
        // Mode 0 always takes, 1 stalls every other cycle, 2 never takes
        dec_ready  = resetn && ((mode_s == 2'd0) || (mode_s == 2'd1 && phase));
        byte_valid = nv;
        byte_data  = nd;
    end

endmodule : ocd_feed_model

`default_nettype wire

// File: dv/tb_top.sv
/*
 Self-checking bench for the opcode subset decoder.
 Assumes the feed model paces the byte stream and the datapath side.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import ocd_pkg::*;

    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [1:0] ready_mode = 2'd0;
    logic       byte_valid, byte_ready, dec_valid, dec_ready;
    logic       dec_has_modrm, dec_unknown;
    logic [7:0] byte_data, dec_modrm, dec_opcode;
    ocd_op_t    dec_op;
    int         bad_count = 0;
    int         samples_checked = 0;

    always #5 ref_clk = ~ref_clk;

    ocd_decoder u_ocd_decoder (.ref_clk(ref_clk), .resetn(resetn), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_ready(byte_ready), .dec_valid(dec_valid),
        .dec_ready(dec_ready), .dec_op(dec_op), .dec_has_modrm(dec_has_modrm),
        .dec_modrm(dec_modrm), .dec_unknown(dec_unknown), .dec_opcode(dec_opcode));

    ocd_feed_model u_ocd_feed_model (.ref_clk(ref_clk), .resetn(resetn),
        .ready_mode(ready_mode), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .dec_valid(dec_valid), .dec_ready(dec_ready),
        .dec_op(dec_op), .dec_has_modrm(dec_has_modrm), .dec_modrm(dec_modrm),
        .dec_unknown(dec_unknown), .dec_opcode(dec_opcode));

    // ========================================================
    // Helpers
    function automatic logic [20:0] rec(ocd_op_t op, logic hm, logic [7:0] m, logic unk,
                                        logic [7:0] opc);
        return {op, hm, m, unk, opc};
    endfunction : rec

    task automatic send(input logic [7:0] b);
        u_ocd_feed_model.tx_q.push_back(b);
    endtask : send

    task automatic set_mode(input logic [1:0] m);
        @(posedge ref_clk);
        #1;
        ready_mode = m;
    endtask : set_mode

    task automatic check_rec(input logic [20:0] exp);
        logic [20:0] got;
        int          n;
        n = 0;
        // Bounded wait so a lost decode shows up as a mismatch
        while (u_ocd_feed_model.rx_q.size() == 0 && n < 100)
        begin
            @(posedge ref_clk);
            n++;
        end
        samples_checked++;
        got = (n < 100) ? u_ocd_feed_model.rx_q.pop_front() : 21'hx;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t decode got %h expected %h", $time, got, exp);
        end
    endtask : check_rec

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t flag got %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    // ========================================================
    // Scenarios
    task automatic run_no_modrm;
        set_mode(2'd0);
        send(8'hd7); send(8'h9f); send(8'h2f); send(8'h99);
        check_rec(rec(OCD_OP_TABLE_LOOKUP_BYTE, 1'b0, 8'h00, 1'b0, 8'hd7));
        check_rec(rec(OCD_OP_FLAGS_TO_ACCUM_HIGH, 1'b0, 8'h00, 1'b0, 8'h9f));
        check_rec(rec(OCD_OP_BCD_FIX_AFTER_SUB, 1'b0, 8'h00, 1'b0, 8'h2f));
        check_rec(rec(OCD_OP_SIGN_EXTEND_WORD_TO_DOUBLE, 1'b0, 8'h00, 1'b0, 8'h99));
    endtask : run_no_modrm

    task automatic run_far_loads;
        // Slow datapath; a ModRM equal to an opcode must not decode as one
        set_mode(2'd1);
        send(8'hc5); send(8'hd7); send(8'hc4); send(8'h3e);
        check_rec(rec(OCD_OP_LOAD_FAR_PTR_DATA_SEGMENT, 1'b1, 8'hd7, 1'b0, 8'hc5));
        check_rec(rec(OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT, 1'b1, 8'h3e, 1'b0, 8'hc4));
    endtask : run_far_loads

    task automatic run_unknown;
        set_mode(2'd0);
        send(8'hd6); send(8'hc6); send(8'h98);
        check_rec(rec(OCD_OP_NONE, 1'b0, 8'h00, 1'b1, 8'hd6));
        check_rec(rec(OCD_OP_NONE, 1'b0, 8'h00, 1'b1, 8'hc6));
        check_rec(rec(OCD_OP_NONE, 1'b0, 8'h00, 1'b1, 8'h98));
    endtask : run_unknown

    task automatic run_stall;
        set_mode(2'd2);
        send(8'h9f); send(8'hc4); send(8'h01);
        repeat (6) @(posedge ref_clk);
        #2;
        check_bit(dec_valid, 1'b1);
        check_bit(byte_ready, 1'b0);
        check_bit(dec_op === OCD_OP_FLAGS_TO_ACCUM_HIGH, 1'b1);
        check_bit(u_ocd_feed_model.rx_q.size() == 0, 1'b1);
        set_mode(2'd0);
        check_rec(rec(OCD_OP_FLAGS_TO_ACCUM_HIGH, 1'b0, 8'h00, 1'b0, 8'h9f));
        check_rec(rec(OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT, 1'b1, 8'h01, 1'b0, 8'hc4));
    endtask : run_stall

    task automatic run_reset;
        // Reset in mid far load must drop the pending ModRM wait
        set_mode(2'd0);
        send(8'hc5);
        repeat (4) @(posedge ref_clk);
        #1;
        resetn = 1'b0;
        #1;
        check_bit(dec_valid, 1'b0);
        check_bit(byte_ready, 1'b1);
        check_bit(dec_has_modrm, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        send(8'h9f);
        check_rec(rec(OCD_OP_FLAGS_TO_ACCUM_HIGH, 1'b0, 8'h00, 1'b0, 8'h9f));
    endtask : run_reset

    // ========================================================
    // Verdict
    task automatic summarize;
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        // Whole run is under a hundred cycles
        #200000;
        bad_count++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        run_no_modrm();
        run_far_loads();
        run_unknown();
        run_stall();
        run_reset();
        summarize();
    end

endmodule : tb_top

`default_nettype wire

// File: inc/ocd_pkg.sv
/*
 Constants and types for the opcode subset decoder: opcode patterns,
 operation identifiers and the decoder state type.
 Assumes one clock and one active-low asynchronous reset.
*/
// Operation
// - Byte 11010111 decodes as table lookup replacing low accumulator byte.
// - Byte 11000101 plus ModRM decodes as far pointer load into data segment.
// - Byte 11000100 plus ModRM decodes as far pointer load into extra segment.
// - Byte 10011111 decodes operand-free: flags low byte into accumulator high.
// - Byte 00101111 decodes operand-free: decimal adjust after subtraction.
// - Byte 10011001 decodes operand-free: accumulator sign-extended into data register.
package ocd_pkg;

    // ========================================================
    // Opcode patterns
    localparam logic [7:0] OP_TABLE_LOOKUP_BYTE      = 8'hd7;
    localparam logic [7:0] OP_LOAD_FAR_PTR_DATA_SEG  = 8'hc5;
    localparam logic [7:0] OP_LOAD_FAR_PTR_EXTRA_SEG = 8'hc4;
    localparam logic [7:0] OP_FLAGS_TO_ACCUM_HIGH    = 8'h9f;
    localparam logic [7:0] OP_BCD_FIX_AFTER_SUB      = 8'h2f;
    localparam logic [7:0] OP_SIGN_EXTEND_WORD       = 8'h99;

    // ========================================================
    // Operation identifiers
    typedef enum logic [2:0] {
        OCD_OP_NONE,
        OCD_OP_TABLE_LOOKUP_BYTE,
        OCD_OP_LOAD_FAR_PTR_DATA_SEGMENT,
        OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT,
        OCD_OP_FLAGS_TO_ACCUM_HIGH,
        OCD_OP_BCD_FIX_AFTER_SUB,
        OCD_OP_SIGN_EXTEND_WORD_TO_DOUBLE
    } ocd_op_t;

    // ========================================================
    // Decoder states
    typedef enum logic [0:0] {
        OCD_ST_OPCODE,
        OCD_ST_MODRM
    } ocd_state_t;

    localparam logic [7:0] OCD_BYTE_RESET = 8'h00;

endpackage : ocd_pkg

// File: src/ocd_decoder.sv
/*
 Opcode subset decoder. Takes bytes from the prefetch queue with a
 valid/ready handshake and issues one decoded instruction per opcode.
 Assumes the queue delivers bytes in program order, synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module ocd_decoder
    import ocd_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            resetn,
    // Byte stream from the prefetch queue
    input  wire logic            byte_valid,
    input  wire logic [7:0]      byte_data,
    output logic                 byte_ready,
    // Decoded instruction to the datapath
    output logic                 dec_valid,
    input  wire logic            dec_ready,
    output var ocd_pkg::ocd_op_t dec_op,
    output logic                 dec_has_modrm,
    output logic [7:0]           dec_modrm,
    output logic                 dec_unknown,
    output logic [7:0]           dec_opcode
);

    // ========================================================
    // State
    typedef struct packed {
        ocd_state_t st;
        logic       valid;
        ocd_op_t    op;
        logic       has_modrm;
        logic [7:0] modrm;
        logic       unknown;
        logic [7:0] opcode;
    } ocd_regs_t;

    ocd_regs_t r_q;
    ocd_regs_t r_d;

    ocd_op_t   lk_op;
    logic      lk_known;
    logic      lk_modrm;

    ocd_lookup u_lookup (
        .opcode    (byte_data),
        .op_id     (lk_op),
        .known     (lk_known),
        .has_modrm (lk_modrm)
    );

    // Stall on a held output; a ModRM byte is always taken
    assign byte_ready    = (r_q.st == OCD_ST_MODRM) || !r_q.valid || dec_ready;
    assign dec_valid     = r_q.valid && (r_q.st == OCD_ST_OPCODE);
    assign dec_op        = r_q.op;
    assign dec_has_modrm = r_q.has_modrm;
    assign dec_modrm     = r_q.modrm;
    assign dec_unknown   = r_q.unknown;
    assign dec_opcode    = r_q.opcode;

    // ========================================================
    // Next state
    always_comb
    begin
        r_d = r_q;
        if (dec_valid && dec_ready)
        begin
            r_d.valid = 1'b0;
        end
        case (r_q.st)
            OCD_ST_OPCODE:
            begin
                if (byte_valid && byte_ready)
                begin
                    r_d.op        = lk_op;
                    r_d.has_modrm = lk_modrm;
                    r_d.unknown   = !lk_known;
                    r_d.opcode    = byte_data;
                    r_d.modrm     = OCD_BYTE_RESET;
                    r_d.valid     = 1'b1;
                    // Unknown bytes are flagged, not stalled on
                    if (lk_modrm)
                    begin
                        r_d.st = OCD_ST_MODRM;
                    end
                end
            end
            OCD_ST_MODRM:
            begin
                if (byte_valid)
                begin
                    r_d.modrm = byte_data;
                    r_d.st    = OCD_ST_OPCODE;
                end
            end
            default: r_d.st = OCD_ST_OPCODE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r_q <= '{st: OCD_ST_OPCODE, valid: 1'b0, op: OCD_OP_NONE,
                     has_modrm: 1'b0, modrm: OCD_BYTE_RESET, unknown: 1'b0,
                     opcode: OCD_BYTE_RESET};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ========================================================
    // Checks
    property p_table_lookup;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_TABLE_LOOKUP_BYTE)
        |=> (dec_valid && dec_op == OCD_OP_TABLE_LOOKUP_BYTE && !dec_has_modrm);
    endproperty
    a_table_lookup: assert property (p_table_lookup)
        else $error("table lookup misdecoded");

    property p_far_load_data;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_LOAD_FAR_PTR_DATA_SEG)
        |=> (r_q.st == OCD_ST_MODRM && !dec_valid
             && r_q.op == OCD_OP_LOAD_FAR_PTR_DATA_SEGMENT && r_q.has_modrm);
    endproperty
    a_far_load_data: assert property (p_far_load_data)
        else $error("data segment load misdecoded");

    property p_far_load_extra;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_LOAD_FAR_PTR_EXTRA_SEG)
        |=> (r_q.st == OCD_ST_MODRM && !dec_valid
             && r_q.op == OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT && r_q.has_modrm);
    endproperty
    a_far_load_extra: assert property (p_far_load_extra)
        else $error("extra segment load misdecoded");

    property p_flags_to_accum;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_FLAGS_TO_ACCUM_HIGH)
        |=> (dec_valid && dec_op == OCD_OP_FLAGS_TO_ACCUM_HIGH && !dec_has_modrm);
    endproperty
    a_flags_to_accum: assert property (p_flags_to_accum)
        else $error("flags transfer misdecoded");

    property p_bcd_fix;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_BCD_FIX_AFTER_SUB)
        |=> (dec_valid && dec_op == OCD_OP_BCD_FIX_AFTER_SUB && !dec_unknown);
    endproperty
    a_bcd_fix: assert property (p_bcd_fix)
        else $error("decimal adjust misdecoded");

    property p_sign_extend;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_OPCODE && byte_valid && byte_ready
         && byte_data == OP_SIGN_EXTEND_WORD)
        |=> (dec_valid && dec_op == OCD_OP_SIGN_EXTEND_WORD_TO_DOUBLE
             && dec_opcode == OP_SIGN_EXTEND_WORD);
    endproperty
    a_sign_extend: assert property (p_sign_extend)
        else $error("sign extend misdecoded");

    property p_modrm_cap;
        @(posedge ref_clk) disable iff (!resetn)
        (r_q.st == OCD_ST_MODRM && byte_valid)
        |=> (dec_valid && dec_modrm == $past(byte_data) && dec_has_modrm);
    endproperty
    a_modrm_cap: assert property (p_modrm_cap)
        else $error("modrm not captured");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (dec_valid && !dec_ready) |=> (dec_valid && $stable(dec_op));
    endproperty
    a_hold: assert property (p_hold)
        else $error("output dropped under stall");

    // Flag and identifier must agree both ways
    property p_unknown;
        @(posedge ref_clk) disable iff (!resetn)
        dec_valid |-> (dec_unknown == (dec_op == OCD_OP_NONE));
    endproperty
    a_unknown: assert property (p_unknown)
        else $error("unknown flag disagrees with op");

    // Judged on the raw opcode, not on the lookup result
    property p_modrm_follows;
        @(posedge ref_clk) disable iff (!resetn)
        (dec_valid && !dec_unknown)
        |-> (dec_has_modrm == (dec_opcode == OP_LOAD_FAR_PTR_DATA_SEG
                               || dec_opcode == OP_LOAD_FAR_PTR_EXTRA_SEG));
    endproperty
    a_modrm_follows: assert property (p_modrm_follows)
        else $error("modrm flag wrong");

    // Datapath may read the ModRM field blindly, so it stays zero
    property p_no_modrm_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (dec_valid && !dec_has_modrm) |-> (dec_modrm == OCD_BYTE_RESET);
    endproperty
    a_no_modrm_clear: assert property (p_no_modrm_clear)
        else $error("stale modrm on plain opcode");

    // A held decode must refuse the next opcode byte
    property p_refuse;
        @(posedge ref_clk) disable iff (!resetn)
        (dec_valid && !dec_ready) |-> !byte_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("byte taken while output held");

    c_far_load_data: cover property (@(posedge ref_clk) disable iff (!resetn)
        dec_valid && dec_op == OCD_OP_LOAD_FAR_PTR_DATA_SEGMENT);
    c_far_load_extra: cover property (@(posedge ref_clk) disable iff (!resetn)
        dec_valid && dec_op == OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT);
    c_table_lookup: cover property (@(posedge ref_clk) disable iff (!resetn)
        dec_valid && dec_op == OCD_OP_TABLE_LOOKUP_BYTE);
    c_stall: cover property (@(posedge ref_clk) disable iff (!resetn)
        dec_valid && !dec_ready ##1 dec_valid && dec_ready);
    c_unknown: cover property (@(posedge ref_clk) disable iff (!resetn)
        dec_valid && dec_unknown);

endmodule : ocd_decoder

`default_nettype wire

// File: src/ocd_lookup.sv
/*
 Pure combinational opcode lookup for the decoder subset.
 Assumes the byte presented is an opcode byte, not a ModRM byte.
*/
`timescale 1ns/100ps
`default_nettype none

module ocd_lookup
    import ocd_pkg::*;
(
    // Opcode in
    input  wire logic [7:0]      opcode,
    // Decode out
    output var ocd_pkg::ocd_op_t op_id,
    output logic                 known,
    output logic                 has_modrm
);

    always_comb
    begin
        op_id     = OCD_OP_NONE;
        has_modrm = 1'b0;
        case (opcode)
            OP_TABLE_LOOKUP_BYTE:   op_id = OCD_OP_TABLE_LOOKUP_BYTE;
            OP_LOAD_FAR_PTR_DATA_SEG:
            begin
                op_id     = OCD_OP_LOAD_FAR_PTR_DATA_SEGMENT;
                has_modrm = 1'b1;
            end
            OP_LOAD_FAR_PTR_EXTRA_SEG:
            begin
                op_id     = OCD_OP_LOAD_FAR_PTR_EXTRA_SEGMENT;
                has_modrm = 1'b1;
            end
            OP_FLAGS_TO_ACCUM_HIGH: op_id = OCD_OP_FLAGS_TO_ACCUM_HIGH;
            OP_BCD_FIX_AFTER_SUB:   op_id = OCD_OP_BCD_FIX_AFTER_SUB;
            OP_SIGN_EXTEND_WORD:    op_id = OCD_OP_SIGN_EXTEND_WORD_TO_DOUBLE;
            default:                op_id = OCD_OP_NONE;
        endcase
        known = (op_id != OCD_OP_NONE);
    end

endmodule : ocd_lookup

`default_nettype wire
